// ### include/udr_pkg.sv
// Behaviour
// - Mode 1: receive request goes low on trigger level reached or character timeout.
// - Mode 1: receive request stays low until the receive FIFO is empty.
// - Mode 0: transmit request is low whenever transmit FIFO or holding register is empty.
// - Mode 0: transmit request goes high once the first character is written.
// - Mode 1: transmit request goes low when the transmit FIFO is empty.
// - Mode 1: transmit request stays low while filling, high only when completely full.
// - FIFO control bits 4 and 5 are reserved and have no function.
// - Trigger field bits 7:6 selects 1, 4, 8 or 14 bytes.
// - Received-data interrupt activates when receive count reaches the trigger level.
// - Received-data interrupt reaches its output only with receive enable bit 0 set.
// - Divisor generator supports divisors 6 down to 2 without divide-by-13 prescale.
// - Mode-select bit switches to mode 1 only while FIFO enable equals 1.
// - Mode 0: receive request low while at least one character is held.
`default_nettype none
package udr_pkg;
  localparam int          SYS_CLK_HZ      = 40000000;
  localparam int          SYS_CLK_NS      = 25;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          CNT_W           = 5;
  localparam int          PRESCALE_DIV    = 13;
  localparam int          DIV_MIN         = 2;
  localparam int          DIV_MAX         = 6;
  // Register byte offsets
  localparam logic [7:0]  OFS_FIFO_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h04;
  localparam logic [7:0]  OFS_DIVISOR     = 8'h08;
  localparam logic [7:0]  OFS_INT_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_INT_MASK    = 8'h10;
  localparam logic [7:0]  OFS_LINE_STATE  = 8'h14;
  // fifo_control fields, then the divisor prescale bit
  localparam int          FC_ENABLE       = 0;
  localparam int          FC_RX_CLEAR     = 1;
  localparam int          FC_TX_CLEAR     = 2;
  localparam int          FC_DMA_SEL      = 3;
  localparam int          FC_TRIG_LSB     = 6;
  localparam int          FC_TRIG_MSB     = 7;
  localparam int          DIV_PRE13_BIT   = 16;
  // Interrupt status bits
  localparam int          IS_TRIGGER      = 0;
  localparam int          IS_TIMEOUT      = 1;
  localparam int          IS_TX_EMPTY     = 2;
  // Trigger levels in bytes
  localparam logic [4:0]  TRIG_LVL_0      = 5'h01;
  localparam logic [4:0]  TRIG_LVL_1      = 5'h04;
  localparam logic [4:0]  TRIG_LVL_2      = 5'h08;
  localparam logic [4:0]  TRIG_LVL_3      = 5'h0E;
  // Reset values
  localparam logic [15:0] RST_DIVISOR     = 16'h0000;
  localparam logic [3:0]  RST_IRQ_EN      = 4'h0;
  localparam logic [2:0]  RST_MASK        = 3'h0;

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = TRIG_LVL_0;
      2'h1: trig_level = TRIG_LVL_1;
      2'h2: trig_level = TRIG_LVL_2;
      2'h3: trig_level = TRIG_LVL_3;
    endcase
  endfunction : trig_level

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_FIFO_CTRL) || (a == OFS_IRQ_EN) || (a == OFS_DIVISOR)
             || (a == OFS_INT_STATUS) || (a == OFS_INT_MASK) || (a == OFS_LINE_STATE);
  endfunction : is_mapped
endpackage : udr_pkg
`default_nettype wire

// ### rtl/udr_baud_div.sv
`default_nettype none
module udr_baud_div (
  input  wire logic        sys_clk,    // System clock
  input  wire logic        nrst,       // Async reset, active low
  input  wire logic [15:0] divisor,    // Divisor for the 16x clock, 0 stops it
  input  wire logic        pre13,      // Divide-by-13 prescale enable
  output var  logic        baud16_en   // One-cycle 16x rate enable
);
  typedef struct packed {
    logic [3:0]  pcnt;
    logic [15:0] dcnt;
    logic        en;
  } udr_div_type;

  udr_div_type st_reg;
  udr_div_type st_next;
  logic        tick;

  always_comb
  begin
    st_next = st_reg;
    st_next.en = 1'b0;
    tick = 1'b1;
    if (pre13)
    begin
      tick = (st_reg.pcnt == 4'(udr_pkg::PRESCALE_DIV - 1));
      st_next.pcnt = tick ? 4'h0 : st_reg.pcnt + 4'h1;
    end
    else
    begin
      st_next.pcnt = 4'h0;
    end
    if (tick)
    begin
      if (st_reg.dcnt <= 16'h0001)
      begin
        st_next.dcnt = divisor;
        st_next.en = (divisor != 16'h0000);
      end
      else
      begin
        st_next.dcnt = st_reg.dcnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign baud16_en = st_reg.en;

  a_div_two_rate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (baud16_en && divisor == 16'h0002 && !pre13) ##1 (divisor == 16'h0002 && !pre13)
    |-> !baud16_en ##1 baud16_en)
    else $error("divisor 2 does not give every second cycle");
endmodule : udr_baud_div
`default_nettype wire

// ### rtl/udr_dma_req.sv
// Local design decisions: register access over APB and the address map.
`default_nettype none
module udr_dma_req #(
  parameter int FIFO_DEPTH = udr_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk,          // System clock, 40 MHz
  input  wire logic        nrst,             // Async reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB write
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output var  logic [31:0] prdata,           // APB read data
  output var  logic        pready,           // APB ready
  output var  logic        pslverr,          // APB error on unmapped address
  input  wire logic [4:0]  rx_count,         // Bytes held in receive side
  input  wire logic [4:0]  tx_count,         // Bytes held in transmit side
  input  wire logic        rx_timeout,       // Character timeout level
  output var  logic        rx_dma_request_n, // Receive DMA request, active low
  output var  logic        tx_dma_request_n, // Transmit DMA request, active low
  output var  logic        rx_data_irq,      // Received-data interrupt, gated
  output var  logic        irq,              // Masked sticky status interrupt
  output var  logic        fifo_mode,        // FIFOs enabled
  output var  logic        rx_fifo_clear,    // One-cycle receive FIFO clear
  output var  logic        tx_fifo_clear,    // One-cycle transmit FIFO clear
  output var  logic        baud16_en         // 16x baud enable pulse
);
  typedef struct packed {
    logic        fifo_en;
    logic        dma_sel;
    logic [1:0]  trig;
    logic [3:0]  ier;
    logic [15:0] divisor;
    logic        pre13;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        rx_req_n;
    logic        tx_req_n;
    logic        rx_irq;
    logic        avail_d;
    logic        tout_d;
    logic        txe_d;
    logic        rx_clr;
    logic        tx_clr;
    logic [31:0] rdata;
  } udr_state_type;

  localparam logic [4:0] FULL_CNT = 5'(FIFO_DEPTH);

  udr_state_type st_reg;
  udr_state_type st_next;
  logic          wr_en;
  logic          rd_setup;
  logic          mode1;
  logic          rx_avail;
  logic          tx_empty;
  logic [2:0]    events;
  logic [2:0]    w1c;

  assign wr_en    = psel && penable && pwrite && udr_pkg::is_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  // Mode 1 only while FIFOs are enabled
  assign mode1    = st_reg.fifo_en && st_reg.dma_sel;
  assign tx_empty = (tx_count == 5'h00);
  assign rx_avail = st_reg.fifo_en ? (rx_count >= udr_pkg::trig_level(st_reg.trig))
                                   : (rx_count != 5'h00);
  assign events   = {tx_empty && !st_reg.txe_d,
                     rx_timeout && !st_reg.tout_d,
                     rx_avail && !st_reg.avail_d};
  assign w1c      = (wr_en && paddr == udr_pkg::OFS_INT_STATUS) ? pwdata[2:0] : 3'h0;

  always_comb
  begin
    st_next = st_reg;
    st_next.rx_clr  = 1'b0;
    st_next.tx_clr  = 1'b0;
    st_next.avail_d = rx_avail;
    st_next.tout_d  = rx_timeout;
    st_next.txe_d   = tx_empty;
    // Set wins over a clear in the same cycle
    st_next.status  = (st_reg.status & ~w1c) | events;
    if (wr_en)
    begin
      unique case (paddr)
        udr_pkg::OFS_FIFO_CTRL:
        begin
          // Mode change between FIFO and character mode flushes both sides
          if (pwdata[udr_pkg::FC_ENABLE] != st_reg.fifo_en)
          begin
            st_next.rx_clr = 1'b1;
            st_next.tx_clr = 1'b1;
          end
          st_next.fifo_en = pwdata[udr_pkg::FC_ENABLE];
          // Other bits are programmed only with enable written as 1
          // Bits 4 and 5 are not stored
          if (pwdata[udr_pkg::FC_ENABLE])
          begin
            st_next.dma_sel = pwdata[udr_pkg::FC_DMA_SEL];
            st_next.trig    = pwdata[udr_pkg::FC_TRIG_MSB:udr_pkg::FC_TRIG_LSB];
            if (pwdata[udr_pkg::FC_RX_CLEAR])
              st_next.rx_clr = 1'b1;
            if (pwdata[udr_pkg::FC_TX_CLEAR])
              st_next.tx_clr = 1'b1;
          end
        end
        udr_pkg::OFS_IRQ_EN:
          st_next.ier = pwdata[3:0];
        udr_pkg::OFS_DIVISOR:
        begin
          st_next.divisor = pwdata[15:0];
          st_next.pre13   = pwdata[udr_pkg::DIV_PRE13_BIT];
        end
        udr_pkg::OFS_INT_MASK:
          st_next.mask = pwdata[2:0];
        default:
        begin
        end
      endcase
    end
    // Read data is captured in the setup cycle so pready can stay high
    if (rd_setup)
    begin
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        udr_pkg::OFS_IRQ_EN:     st_next.rdata = {28'h0, st_reg.ier};
        udr_pkg::OFS_DIVISOR:    st_next.rdata = {15'h0, st_reg.pre13, st_reg.divisor};
        udr_pkg::OFS_INT_STATUS: st_next.rdata = {29'h0, st_reg.status};
        udr_pkg::OFS_INT_MASK:   st_next.rdata = {29'h0, st_reg.mask};
        udr_pkg::OFS_LINE_STATE: st_next.rdata = {15'h0, tx_count, 3'h0, rx_count,
                                                  mode1, st_reg.fifo_en,
                                                  st_reg.tx_req_n, st_reg.rx_req_n};
        default:                 st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (mode1)
    begin
      // Held low until receive side empties
      if (rx_count == 5'h00)
        st_next.rx_req_n = 1'b1;
      else if (rx_avail || rx_timeout)
        st_next.rx_req_n = 1'b0;
      if (tx_count >= FULL_CNT)
        st_next.tx_req_n = 1'b1;
      else if (tx_empty)
        st_next.tx_req_n = 1'b0;
    end
    else
    begin
      // Receive low while any character is held, transmit low while empty
      st_next.rx_req_n = (rx_count == 5'h00);
      st_next.tx_req_n = !tx_empty;
    end
    st_next.rx_irq = st_reg.ier[0] && (rx_avail || (st_reg.fifo_en && rx_timeout));
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg          <= '0;
      st_reg.ier      <= udr_pkg::RST_IRQ_EN;
      st_reg.divisor  <= udr_pkg::RST_DIVISOR;
      st_reg.mask     <= udr_pkg::RST_MASK;
      st_reg.avail_d  <= 1'b0;
      st_reg.txe_d    <= 1'b1;
      st_reg.rx_req_n <= 1'b1;
      st_reg.tx_req_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  udr_baud_div u_div (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .divisor   (st_reg.divisor),
    .pre13     (st_reg.pre13),
    .baud16_en (baud16_en)
  );

  assign prdata           = st_reg.rdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !udr_pkg::is_mapped(paddr);
  assign rx_dma_request_n = st_reg.rx_req_n;
  assign tx_dma_request_n = st_reg.tx_req_n;
  assign rx_data_irq      = st_reg.rx_irq;
  assign irq              = |(st_reg.status & st_reg.mask);
  assign fifo_mode        = st_reg.fifo_en;
  assign rx_fifo_clear    = st_reg.rx_clr;
  assign tx_fifo_clear    = st_reg.tx_clr;

  a_rx_mode0_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    !mode1 |=> rx_dma_request_n == ($past(rx_count) == 5'h00))
    else $error("mode 0 receive request does not follow occupancy");
  a_rx_mode1_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode1 && rx_count == 5'h00) |=> rx_dma_request_n)
    else $error("mode 1 receive request not released on empty");
  a_rx_mode1_trigger: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode1 && rx_count != 5'h00 && (rx_timeout || rx_count >= udr_pkg::trig_level(st_reg.trig)))
    |=> !rx_dma_request_n)
    else $error("mode 1 receive request missing at trigger or timeout");
  a_tx_mode0_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    !mode1 |=> tx_dma_request_n == ($past(tx_count) != 5'h00))
    else $error("mode 0 transmit request does not follow occupancy");
  a_tx_mode1_empty: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode1 && tx_count == 5'h00) |=> !tx_dma_request_n)
    else $error("mode 1 transmit request missing on empty");
  a_tx_mode1_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode1 && tx_count != 5'h00 && tx_count < FULL_CNT) |=> $stable(tx_dma_request_n))
    else $error("mode 1 transmit request moved while partly full");
  a_tx_mode1_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode1 && tx_count >= FULL_CNT) |=> tx_dma_request_n)
    else $error("mode 1 transmit request not released when full");
  a_rx_irq_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    !st_reg.ier[0] |=> !rx_data_irq)
    else $error("received-data interrupt passed while disabled");
  a_rx_irq_trigger: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_reg.ier[0] && st_reg.fifo_en && rx_count == udr_pkg::trig_level(st_reg.trig))
    |=> rx_data_irq)
    else $error("received-data interrupt missing at trigger level");
  a_dma_sel_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_en && paddr == udr_pkg::OFS_FIFO_CTRL && !pwdata[udr_pkg::FC_ENABLE])
    |=> !mode1 && $stable(st_reg.dma_sel))
    else $error("mode select programmed with FIFOs disabled");
endmodule : udr_dma_req
`default_nettype wire

// ### rtl/dummy_none.sv
`default_nettype none
`default_nettype wire

// ### tb/udr_far_model.sv
`default_nettype none
module udr_far_model (
  input  wire logic       sys_clk,  // System clock
  input  wire logic       nrst,     // Async reset, active low
  input  wire logic [4:0] rx_lvl,   // Receive occupancy to reach
  input  wire logic [4:0] tx_lvl,   // Transmit occupancy to reach
  output var  logic [4:0] rx_count, // Bytes held in receive side
  output var  logic [4:0] tx_count  // Bytes held in transmit side
);
  timeunit 1ns;
  timeprecision 1ps;
  // One byte a cycle, so every level between is passed as a real core would
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      rx_count <= 5'h00;
      tx_count <= 5'h00;
    end
    else
    begin
      if (rx_count < rx_lvl) rx_count <= rx_count + 5'h01;
      else if (rx_count > rx_lvl) rx_count <= rx_count - 5'h01;
      if (tx_count < tx_lvl) tx_count <= tx_count + 5'h01;
      else if (tx_count > tx_lvl) tx_count <= tx_count - 5'h01;
    end
endmodule : udr_far_model
`default_nettype wire

// ### tb/udr_dma_req_tb.sv
`default_nettype none
module udr_dma_req_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] e;} udr_note_type;
  logic         sys_clk = 1'b0;
  logic         nrst    = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [7:0]   paddr   = 8'h00;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata, rd, obs;
  logic         pready, pslverr, err, rxn, txn, rx_data_irq, irq, rx_timeout = 1'b0;
  logic [4:0]   rx_count, tx_count, rx_lvl = 5'h00, tx_lvl = 5'h00;
  udr_note_type q[$];
  int           bad_count = 0;
  int           tests_run = 0;
  int           cyc       = 0;
  int           nb        = 0;
  logic         fm, rxc, txc, b16;
  int           seed      = 68;
  int           trig_tab[4] = '{1, 4, 8, 14};
  event         probe;

  udr_dma_req DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_count(rx_count), .tx_count(tx_count), .rx_timeout(rx_timeout),
    .rx_dma_request_n(rxn), .tx_dma_request_n(txn), .rx_data_irq(rx_data_irq), .irq(irq),
    .fifo_mode(fm), .rx_fifo_clear(rxc), .tx_fifo_clear(txc), .baud16_en(b16));
  udr_far_model far (.sys_clk(sys_clk), .nrst(nrst), .rx_lvl(rx_lvl), .tx_lvl(tx_lvl),
    .rx_count(rx_count), .tx_count(tx_count));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask : chk

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Oldest note is matched against what the driver just saw
  always @(probe)
  begin
    chk(q[0].nm, obs, q[0].e);
    void'(q.pop_front());
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end

  task note(input string nm, input logic [31:0] e, input logic [31:0] o);
    q.push_back('{nm, e});
    obs = o;
    ->probe;
    #1;
  endtask : note

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Moves the far side, lets requests settle, notes {rx_n, tx_n, rx_data_irq}
  task step(input logic [4:0] r, input logic [4:0] t, input logic to, input logic [2:0] e);
    @(posedge sys_clk);
    rx_lvl <= r;
    tx_lvl <= t;
    rx_timeout <= to;
    for (int k = 0; k < 40 && (rx_count !== r || tx_count !== t); k++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    #1;
    note("requests", {29'h0, e}, {29'h0, rxn, txn, rx_data_irq});
  endtask : step

  task irq_is(input logic e);
    @(posedge sys_clk);
    #1;
    note("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is

  // Notes {fifo_mode, rx clear, tx clear} in the pulse cycle and once the pulse is over
  task ctl(input logic [31:0] d, input logic [2:0] e);
    apb(1'b1, udr_pkg::OFS_FIFO_CTRL, d);
    #1;
    note("clears", {29'h0, e}, {29'h0, fm, rxc, txc});
    @(posedge sys_clk);
    #1;
    note("clear pulse end", {29'h0, e[2], 2'b00}, {29'h0, fm, rxc, txc});
  endtask : ctl

  // Window is a whole number of periods for every divisor, so the phase does not matter
  task baud(input int d, input logic p);
    apb(1'b1, udr_pkg::OFS_DIVISOR, 32'(d) | (32'(p) << udr_pkg::DIV_PRE13_BIT));
    apb(1'b0, udr_pkg::OFS_DIVISOR, 32'h0);
    note("divisor read", 32'(d) | (32'(p) << udr_pkg::DIV_PRE13_BIT), rd);
    repeat (100) @(posedge sys_clk);
    nb = 0;
    repeat (p ? 780 : 60)
    begin
      @(posedge sys_clk);
      #1;
      nb = nb + int'(b16);
    end
    note("baud16 enables", 32'(60 / d), 32'(nb));
  endtask : baud

  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1;
    note("reset", 32'h3, {30'h0, rxn, txn});
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    step(5'd1, 5'd0, 1'b0, 3'b000);
    step(5'd0, 5'd3, 1'b0, 3'b110);
    step(5'd0, 5'd0, 1'b0, 3'b100);
    $display("test char_mode done");
    apb(1'b1, udr_pkg::OFS_IRQ_EN, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      // Reserved bits carry random junk and must change nothing
      apb(1'b1, udr_pkg::OFS_FIFO_CTRL, 32'h9 | (i << 6) | ($random(seed) & 32'h30));
      step(5'(trig_tab[i] - 1), 5'd0, 1'b0, 3'b100);
      step(5'(trig_tab[i]), 5'd0, 1'b0, 3'b001);
      step(5'd1, 5'd0, 1'b0, {2'b00, i == 0});
      step(5'd0, 5'd0, 1'b0, 3'b100);
    end
    step(5'd2, 5'd0, 1'b1, 3'b001);
    step(5'd0, 5'd0, 1'b0, 3'b100);
    step(5'd0, 5'd8, 1'b0, 3'b100);
    step(5'd0, 5'd16, 1'b0, 3'b110);
    step(5'd0, 5'd15, 1'b0, 3'b110);
    step(5'd0, 5'd0, 1'b0, 3'b100);
    $display("test dma_mode done");
    apb(1'b1, udr_pkg::OFS_FIFO_CTRL, 32'h8);
    step(5'd1, 5'd0, 1'b0, 3'b001);
    step(5'd0, 5'd0, 1'b0, 3'b100);
    $display("test mode_gate done");
    ctl(32'h1, 3'b111);
    ctl(32'h3, 3'b110);
    ctl(32'h5, 3'b101);
    ctl(32'h6, 3'b011);
    $display("test clears done");
    apb(1'b0, udr_pkg::OFS_FIFO_CTRL, 32'h0);
    note("fifo_control read", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    note("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, udr_pkg::OFS_IRQ_EN, 32'h0);
    note("irq_enable read", 32'h1, rd);
    apb(1'b1, udr_pkg::OFS_INT_MASK, 32'h4);
    irq_is(1'b1);
    apb(1'b1, udr_pkg::OFS_INT_STATUS, 32'h7);
    irq_is(1'b0);
    apb(1'b1, udr_pkg::OFS_INT_MASK, 32'h0);
    step(5'd0, 5'd3, 1'b0, 3'b110);
    apb(1'b0, udr_pkg::OFS_LINE_STATE, 32'h0);
    note("line_state read", 32'h0000_3003, rd);
    step(5'd0, 5'd0, 1'b0, 3'b100);
    irq_is(1'b0);
    apb(1'b1, udr_pkg::OFS_INT_MASK, 32'h4);
    irq_is(1'b1);
    apb(1'b1, udr_pkg::OFS_INT_STATUS, 32'h4);
    irq_is(1'b0);
    $display("test registers done");
    for (int d = udr_pkg::DIV_MIN; d <= udr_pkg::DIV_MAX; d++)
      baud(d, 1'b0);
    baud(udr_pkg::DIV_MIN + 1, 1'b1);
    $display("test baud done");
    results();
  end
endmodule : udr_dma_req_tb
`default_nettype wire
